// ---- bench/ecpr_periph_model.sv ----
// Printer model on the far side of the parallel port pins.
`timescale 1ns/1ns
`default_nettype none
module ecpr_periph_model
  import ecpr_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire ecpr_pins_out_s pinsOut, // Control pins from the port.
  input wire logic [7:0] dataLines, // Resolved data line levels.
  input wire logic slow, // Stretches each reply by a few cycles.
  input wire logic [4:0] idleLvl, // Pin levels while idle.
  output ecpr_pins_in_s pinsIn, // Status pins to the port.
  output logic [7:0] capByte, // Last byte taken from the lines.
  output logic capTag, // Feed line was low when it was taken.
  output logic [7:0] capCount // Completed transfers.
);
  logic [1:0] st = 2'h0; // Handshake step.
  logic [2:0] wt = 3'h0; // Wait counter.
  logic ackR = 1'b1; // Acknowledge line.
  logic busyR = 1'b0; // Busy line.
  initial capCount = 8'h00;
  initial capByte = 8'h00;
  initial capTag = 1'b0;
  assign pinsIn = {idleLvl[4:2], ackR, busyR};
  // Interlocked strobe and busy, then an acknowledge pulse of a few cycles.
  always @(posedge mclk)
  begin
    case (st)
      2'h0:
      begin
        ackR <= idleLvl[1];
        busyR <= idleLvl[0];
        if (!pinsOut.strobeN)
        begin
          capByte <= dataLines;
          capTag <= !pinsOut.feedN;
          busyR <= 1'b1;
          wt <= slow ? 3'h6 : 3'h0;
          st <= 2'h1;
        end
      end
      2'h1: if (pinsOut.strobeN) st <= 2'h2;
      2'h2:
      begin
        if (wt != 3'h0) wt <= wt - 3'h1;
        else
        begin
          ackR <= 1'b0;
          wt <= 3'h2;
          st <= 2'h3;
        end
      end
      default:
      begin
        if (wt != 3'h0) wt <= wt - 3'h1;
        else
        begin
          ackR <= 1'b1;
          busyR <= 1'b0;
          capCount <= capCount + 8'h01;
          st <= 2'h0;
        end
      end
    endcase
  end
endmodule // ecpr_periph_model
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking testbench for the parallel port register bank.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ecpr_pkg::*;
  localparam logic [15:0] BASE = 16'h0378; // Port base address.
  logic mclk = 1'b0; // System clock.
  logic reset = 1'b1; // Synchronous reset.
  logic [15:0] hostAddr = 16'h0000; // Host address.
  logic hostWr = 1'b0; // Write strobe.
  logic hostRd = 1'b0; // Read strobe.
  logic [7:0] hostWdata = 8'h00; // Write byte.
  logic [7:0] hostRdata; // Read byte.
  logic [3:0] irqNumber = 4'h7; // Assigned interrupt line.
  logic [1:0] dmaChannel = 2'h3; // Assigned DMA channel.
  logic eppEnable = 1'b0; // Enhanced mode allowed.
  ecpr_pins_in_s pinsIn; // Status pins.
  ecpr_pins_out_s pinsOut; // Control pins.
  logic [7:0] pdIn; // Data line levels.
  logic [7:0] pdOut; // Data line drive.
  logic pdOe; // Data drive enable.
  logic irqOut; // Interrupt pulse.
  logic slow = 1'b0; // Slow printer replies.
  logic [4:0] lvl = 5'h1A; // Idle status levels.
  logic [7:0] capByte; // Byte the printer took.
  logic capTag; // Address tag seen by the printer.
  logic [7:0] capCount; // Printer transfer count.
  logic [7:0] prevCount = 8'h00; // Count at last edge.
  logic [8:0] capQ[$]; // Tag and byte of each transfer.
  int irqCnt = 0; // Interrupt pulses seen.
  int bad_count = 0; // Mismatches.
  int num_checks = 0; // Comparisons.
  int i; // Loop index.
  logic [7:0] irqTab[3] = '{8'h07, 8'h05, 8'h0F}; // Interrupt lines tried.
  logic [7:0] cfgTab[3] = '{8'h0B, 8'h38, 8'h32}; // Expected config B.
  initial forever #20 mclk = ~mclk;
  // Released lines read back the inverse so a stale value cannot pass.
  assign pdIn = pdOe ? pdOut : ~pdOut;
  ecpr_regs DUT (.mclk(mclk), .reset(reset), .hostAddr(hostAddr), .hostWr(hostWr),
    .hostRd(hostRd), .hostWdata(hostWdata), .hostRdata(hostRdata), .baseAddr(BASE),
    .eppEnable(eppEnable), .irqNumber(irqNumber), .dmaChannel(dmaChannel), .pinsIn(pinsIn),
    .pdIn(pdIn), .pdOut(pdOut), .pdOe(pdOe), .pinsOut(pinsOut), .irqOut(irqOut));
  ecpr_periph_model PRN (.mclk(mclk), .pinsOut(pinsOut), .dataLines(pdIn), .slow(slow),
    .idleLvl(lvl), .pinsIn(pinsIn), .capByte(capByte), .capTag(capTag),
    .capCount(capCount));
  // Records interrupt pulses and each finished printer transfer.
  always @(posedge mclk)
  begin
    if (irqOut === 1'b1) irqCnt++;
    if (capCount != prevCount) capQ.push_back({capTag, capByte});
    prevCount = capCount;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] ofs, input logic [7:0] d);
    @(negedge mclk);
    hostAddr = BASE + ofs;
    hostWdata = d;
    hostWr = 1'b1;
    @(negedge mclk);
    hostWr = 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [15:0] ofs, input logic [7:0] exp);
    @(negedge mclk);
    hostAddr = BASE + ofs;
    hostRd = 1'b1;
    @(negedge mclk);
    hostRd = 1'b0;
    @(negedge mclk);
    chk(nm, exp, hostRdata);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Waits for the printer to finish n transfers, under a bound.
  task automatic waitCaps(input int n);
    for (i = 0; i < 3000 && capQ.size() < n; i++) @(negedge mclk);
    if (capQ.size() < n)
    begin
      bad_count++;
      $display("MISMATCH printer transfers expected %0d seen %0d", n, capQ.size());
      tally_and_finish;
    end
  endtask
  task automatic t_reset;
    chk("pins", 8'h0D, {4'h0, pinsOut});
    chk("pdOut", 8'h00, pdOut);
    rdc("ctrl", 16'h0002, 8'h00);
    rdc("ecr", 16'h0402, 8'h01);
    // The enhanced mode is refused until the setup input allows it.
    wr(16'h0402, 8'h80);
    rdc("ecr epp off", 16'h0402, 8'h01);
    eppEnable = 1'b1;
    wr(16'h0402, 8'h80);
    rdc("ecr epp on", 16'h0402, 8'h81);
    wr(16'h0402, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_data;
    wr(16'h0000, 8'hA5);
    // The pins lag the latch by one edge and the read path by two more.
    repeat (2) @(negedge mclk);
    chk("pdOut", 8'hA5, pdOut);
    rdc("data", 16'h0000, 8'hA5);
    wr(16'h0402, 8'h20);
    wr(16'h0002, 8'h20);
    @(negedge mclk);
    chk("pdOe", 8'h00, {7'h0, pdOe});
    repeat (3) @(negedge mclk);
    rdc("data in", 16'h0000, 8'h5A);
    wr(16'h0402, 8'h00);
    @(negedge mclk);
    chk("pdOe", 8'h01, {7'h0, pdOe});
    wr(16'h0002, 8'h00);
    $display("data test done");
  endtask
  task automatic t_status;
    lvl = 5'h15;
    repeat (4) @(negedge mclk);
    rdc("status", 16'h0001, 8'h28);
    lvl = 5'h0A;
    repeat (4) @(negedge mclk);
    rdc("status", 16'h0001, 8'hD0);
    lvl = 5'h1A;
    repeat (4) @(negedge mclk);
    rdc("status", 16'h0001, 8'hD8);
    $display("status test done");
  endtask
  task automatic t_ctrl;
    wr(16'h0002, 8'hEF);
    rdc("ctrl", 16'h0002, 8'h2F);
    chk("pins", 8'h02, {4'h0, pinsOut});
    wr(16'h0002, 8'h00);
    $display("control test done");
  endtask
  task automatic t_config;
    wr(16'h0402, 8'hE0);
    rdc("cfgA", 16'h0400, 8'h10);
    for (int k = 0; k < 3; k++)
    begin
      irqNumber = irqTab[k][3:0];
      dmaChannel = cfgTab[k][1:0];
      rdc("cfgB", 16'h0401, cfgTab[k]);
    end
    rdc("unmapped", 16'h0403, 8'h00);
    wr(16'h0402, 8'h00);
    $display("config test done");
  endtask
  task automatic t_loop;
    logic [7:0] c0;
    c0 = capCount;
    wr(16'h0402, 8'hC0);
    wr(16'h0400, 8'h44);
    wr(16'h0400, 8'h33);
    wr(16'h0400, 8'h22);
    chk("pdOut head", 8'h44, pdOut);
    rdc("fifo", 16'h0400, 8'h44);
    rdc("fifo", 16'h0400, 8'h33);
    rdc("fifo", 16'h0400, 8'h22);
    rdc("fifo empty", 16'h0400, 8'h22);
    rdc("ecr", 16'h0402, 8'hC1);
    for (int k = 0; k < 17; k++) wr(16'h0400, 8'(k));
    rdc("ecr full", 16'h0402, 8'hC2);
    for (int k = 0; k < 16; k++) rdc("fifo", 16'h0400, 8'(k));
    rdc("ecr", 16'h0402, 8'hC1);
    chk("no handshake", c0, capCount);
    wr(16'h0402, 8'h00);
    $display("test fifo test done");
  endtask
  task automatic t_compat;
    capQ.delete();
    irqCnt = 0;
    slow = 1'b1;
    wr(16'h0002, 8'h10);
    wr(16'h0402, 8'h40);
    wr(16'h0400, 8'h5A);
    wr(16'h0400, 8'hC3);
    waitCaps(2);
    repeat (8) @(negedge mclk);
    chk("byte0", 8'h5A, capQ[0][7:0]);
    chk("byte1", 8'hC3, capQ[1][7:0]);
    chk("irq", 8'h02, 8'(irqCnt));
    wr(16'h0402, 8'h00);
    wr(16'h0002, 8'h00);
    $display("compat test done");
  endtask
  task automatic t_ecp;
    capQ.delete();
    irqCnt = 0;
    slow = 1'b0;
    wr(16'h0402, 8'h60);
    wr(16'h0000, 8'h81);
    wr(16'h0400, 8'h7E);
    waitCaps(2);
    chk("addr tag", 8'h01, {7'h0, capQ[0][8]});
    chk("addr", 8'h81, capQ[0][7:0]);
    chk("data tag", 8'h00, {7'h0, capQ[1][8]});
    chk("data", 8'h7E, capQ[1][7:0]);
    repeat (8) @(negedge mclk);
    chk("no irq", 8'h00, 8'(irqCnt));
    wr(16'h0402, 8'h00);
    $display("ecp test done");
  endtask
  // Reverse capture: released lines read back the inverse of the latch.
  task automatic t_rev;
    wr(16'h0000, 8'h3C);
    wr(16'h0002, 8'h20);
    wr(16'h0402, 8'h60);
    @(negedge mclk);
    chk("pdOe rev", 8'h00, {7'h0, pdOe});
    lvl = 5'h18;
    repeat (6) @(negedge mclk);
    lvl = 5'h1A;
    repeat (6) @(negedge mclk);
    rdc("rev byte", 16'h0400, 8'hC3);
    rdc("rev ecr", 16'h0402, 8'h61);
    wr(16'h0402, 8'h00);
    wr(16'h0002, 8'h00);
    $display("reverse test done");
  endtask
  initial
  begin
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    t_reset();
    t_data();
    t_status();
    t_ctrl();
    t_config();
    t_loop();
    t_compat();
    t_ecp();
    t_rev();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire

// ---- hdl/ecpr_consts.svh ----
// Named constants for the multi-mode parallel port register bank.
`ifndef ECPR_CONSTS_SVH
`define ECPR_CONSTS_SVH
// Register offsets from the port base address.
`define ECPR_OFS_DATA 16'h0000
`define ECPR_OFS_STAT 16'h0001
`define ECPR_OFS_CTRL 16'h0002
`define ECPR_OFS_FIFO 16'h0400
`define ECPR_OFS_CFGB 16'h0401
`define ECPR_OFS_ECR 16'h0402
// Mode field encodings.
`define ECPR_M_SPP 3'h0
`define ECPR_M_BIDIR 3'h1
`define ECPR_M_COMPAT_FIFO_PORT 3'h2
`define ECPR_M_ECP 3'h3
`define ECPR_M_EPP 3'h4
`define ECPR_M_TEST 3'h6
`define ECPR_M_CFG 3'h7
// Control register bit positions and writable mask.
`define ECPR_C_STB 0
`define ECPR_C_FEED 1
`define ECPR_C_INIT 2
`define ECPR_C_SELIN 3
`define ECPR_C_ACKIE 4
`define ECPR_C_DIR 5
`define ECPR_CTRL_MASK 8'h3F
// Extended control field positions.
`define ECPR_E_MODE_HI 7
`define ECPR_E_MODE_LO 5
`define ECPR_E_ERRIE 4
`define ECPR_E_DMAEN 3
`define ECPR_E_SVC 2
// Fixed values and reset values.
`define ECPR_CFGA_VAL 8'h10
`define ECPR_BYTE_ZERO 8'h00
`define ECPR_LOW3 3'h0
`define ECPR_CTRL_RST 6'h00
// FIFO geometry: a tag bit plus one byte, sixteen entries.
`define ECPR_FIFO_W 9
`define ECPR_FIFO_D 16
`define ECPR_FIFO_AW 4
`endif

// ---- hdl/ecpr_fifo.sv ----
// Sixteen-entry flop FIFO used by the parallel port transfer modes.
`timescale 1ns/1ns
`default_nettype none
`include "ecpr_consts.svh"
module ecpr_fifo
  import ecpr_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic flush, // Empties the FIFO.
  input wire logic pushValid, // Offer of a new entry.
  input wire logic [`ECPR_FIFO_W-1:0] pushData, // Entry offered.
  output logic pushReady, // High while an entry can be taken.
  output logic popValid, // High while the head holds data.
  input wire logic popReady, // Removes the head entry.
  output logic [`ECPR_FIFO_W-1:0] popData // Head entry.
);
  logic [`ECPR_FIFO_W-1:0] mem [`ECPR_FIFO_D]; // Entry storage.
  logic [`ECPR_FIFO_AW-1:0] wrPtr_r; // Next slot to write.
  logic [`ECPR_FIFO_AW-1:0] rdPtr_r; // Head slot.
  logic [`ECPR_FIFO_AW:0] count_r; // Occupancy, zero to sixteen.
  logic doPush; // An entry goes in this cycle.
  logic doPop; // An entry leaves this cycle.

  // A push to a full FIFO is simply dropped, so flags stay honest.
  assign pushReady = (count_r != 5'(`ECPR_FIFO_D));
  assign popValid = (count_r != 5'h00);
  assign popData = mem[rdPtr_r];
  assign doPush = pushValid && pushReady;
  assign doPop = popReady && popValid;

  // Pointers and occupancy move together.
  always_ff @(posedge mclk)
  begin
    if (reset || flush)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr_r <= wrPtr_r + 4'h1;
      if (doPop)
        rdPtr_r <= rdPtr_r + 4'h1;
      count_r <= count_r + {4'h0, doPush} - {4'h0, doPop};
    end
  end

  // Storage has no reset; popData shows the head slot even while the FIFO is empty.
  always_ff @(posedge mclk)
  begin
    if (doPush)
      mem[wrPtr_r] <= pushData;
  end
endmodule // ecpr_fifo
`default_nettype wire

// ---- hdl/ecpr_pkg.sv ----
// Types shared by the parallel port register bank files.
package ecpr_pkg;
  // Peripheral status inputs, as seen on the pins.
  typedef struct packed {
    logic fault;
    logic online;
    logic paperErr;
    logic ack;
    logic busy;
  } ecpr_pins_in_s;
  // Peripheral control outputs, as driven on the pins.
  typedef struct packed {
    logic strobeN;
    logic feedN;
    logic init;
    logic selInN;
  } ecpr_pins_out_s;
  // Handshake engine states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STROBE,
    ST_RELEASE,
    ST_RXACK,
    ST_RXDONE
  } ecpr_hs_e;
endpackage

// ---- hdl/ecpr_regs.sv ----
// Host register bank and pin logic of a multi-mode parallel port.
//
// Summary of operation
// - Offset zero: data latch, or address FIFO.
// - Three-bit mode field selects seven port modes.
// - Offsets add to base; upper offsets decoded.
// - Reset clears latch; writes drive data lines.
// - Modes 000/001 read data line levels.
// - Mode 011 address writes queue tagged bytes.
// - Status bits zero to two read zero.
// - Status bits three to six show inputs.
// - Status bit seven reads busy inverted.
// - Control low six bits reset; top zero.
// - Control bits drive strobe, feed, init, select.
// - Enabled acknowledge rising edge raises interrupt.
// - Direction bit, forced output in 000/010.
// - Mode 010 FIFO bytes sent by handshake.
// - Mode 011 sends or captures by direction.
// - Test FIFO: no handshake, data shown.
// - Write to full test FIFO discarded.
// - Read of empty test FIFO repeats byte.
// - Test FIFO reads in order, full rate.
// - Configuration A reads fixed word-size value.
// - Config B: no compression, interrupt level.
// - Config B reports encoded interrupt line.
// - Config B reports encoded DMA channel.
`timescale 1ns/1ns
`default_nettype none
`include "ecpr_consts.svh"
module ecpr_regs
  import ecpr_pkg::*;
(
  input wire logic mclk, // System clock, 25 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic [15:0] hostAddr, // Host I/O address.
  input wire logic hostWr, // Host write strobe, one cycle.
  input wire logic hostRd, // Host read strobe, one cycle.
  input wire logic [7:0] hostWdata, // Host write byte.
  output logic [7:0] hostRdata, // Read byte, valid after a read.
  input wire logic [15:0] baseAddr, // Port base address from setup.
  input wire logic eppEnable, // Allows the enhanced mode.
  input wire logic [3:0] irqNumber, // Interrupt line assigned.
  input wire logic [1:0] dmaChannel, // DMA channel assigned.
  input wire ecpr_pins_in_s pinsIn, // Peripheral status pins.
  input wire logic [7:0] pdIn, // Data line levels.
  output logic [7:0] pdOut, // Data line drive value.
  output logic pdOe, // High while the data lines are driven.
  output ecpr_pins_out_s pinsOut, // Peripheral control pins.
  output logic irqOut // Acknowledge interrupt request pulse.
);
  logic [7:0] dataLatch_r; // Host data register.
  logic [5:0] ctrl_r; // Stored control bits.
  logic [2:0] mode_r; // Current mode field.
  logic errIe_r; // Error interrupt enable bit.
  logic dmaEn_r; // DMA enable bit.
  logic svc_irq_flag_r; // Service interrupt bit.
  logic [7:0] lastRd_r; // Last byte taken from the FIFO.
  logic [7:0] txByte_r; // Byte being sent forward.
  logic txTag_r; // Byte being sent is an address.
  ecpr_hs_e hs_r; // Handshake state.
  ecpr_pins_in_s pinS1_r; // First synchroniser stage.
  ecpr_pins_in_s pinS_r; // Synchronised status pins.
  logic [7:0] pdS1_r; // First data synchroniser stage.
  logic [7:0] pdS_r; // Synchronised data lines.
  logic ackD_r; // Delayed acknowledge for edges.
  logic hitData, hitStat, hitCtrl, hitFifo, hitCfgb, hitEcr; // Decodes.
  logic dirIn; // Effective direction is input.
  logic autoFwd; // Hardware forward transfer mode.
  logic autoRev; // Hardware reverse capture mode.
  logic fifoPush, fifoPushReady, fifoPop, fifoValid; // FIFO handshake.
  logic [8:0] fifoIn, fifoHead; // FIFO entries.
  logic hostFifoRd; // Host takes a byte from the FIFO.
  logic modeOk; // Requested mode change is legal.
  logic [2:0] newMode; // Mode field of a write.
  logic [7:0] rdMux; // Read data before the register.

  // Each offset is relative to the configured base address.
  assign hitData = (hostAddr == 16'(baseAddr + `ECPR_OFS_DATA));
  assign hitStat = (hostAddr == 16'(baseAddr + `ECPR_OFS_STAT));
  assign hitCtrl = (hostAddr == 16'(baseAddr + `ECPR_OFS_CTRL));
  assign hitFifo = (hostAddr == 16'(baseAddr + `ECPR_OFS_FIFO));
  assign hitCfgb = (hostAddr == 16'(baseAddr + `ECPR_OFS_CFGB));
  assign hitEcr = (hostAddr == 16'(baseAddr + `ECPR_OFS_ECR));

  // Direction bit is ignored in standard and compatibility FIFO modes.
  assign dirIn = ctrl_r[`ECPR_C_DIR] && (mode_r != `ECPR_M_SPP)
    && (mode_r != `ECPR_M_COMPAT_FIFO_PORT);
  assign autoFwd = (mode_r == `ECPR_M_COMPAT_FIFO_PORT)
    || ((mode_r == `ECPR_M_ECP) && !dirIn);
  assign autoRev = (mode_r == `ECPR_M_ECP) && dirIn;

  // Mode changes go only through standard or bidirectional modes.
  assign newMode = hostWdata[`ECPR_E_MODE_HI:`ECPR_E_MODE_LO];
  assign modeOk = ((mode_r == `ECPR_M_SPP) || (mode_r == `ECPR_M_BIDIR)
    || (newMode == `ECPR_M_SPP) || (newMode == `ECPR_M_BIDIR))
    && ((newMode != `ECPR_M_EPP) || eppEnable);

  // Host FIFO reads happen in test mode and reverse capture mode.
  assign hostFifoRd = hostRd && hitFifo
    && ((mode_r == `ECPR_M_TEST) || autoRev);

  // One queue carries host bytes forward or peripheral bytes back.
  always_comb
  begin
    fifoPush = 1'b0;
    fifoIn = {1'b0, hostWdata};
    if (hostWr && hitData && (mode_r == `ECPR_M_ECP) && !dirIn)
    begin
      // Address or run-length byte, tagged for the feed line.
      fifoPush = 1'b1;
      fifoIn = {1'b1, hostWdata};
    end
    else if (hostWr && hitFifo && (autoFwd || (mode_r == `ECPR_M_TEST)))
      fifoPush = 1'b1;
    else if ((hs_r == ST_RXACK) && !pinS_r.ack)
    begin
      // Peripheral byte captured while acknowledge is low.
      fifoPush = 1'b1;
      fifoIn = {1'b0, pdS_r};
    end
  end

  // The engine pops when busy falls after a send; the host pops on a read.
  assign fifoPop = ((hs_r == ST_RELEASE) && !pinS_r.busy)
    || hostFifoRd;

  ecpr_fifo u_fifo (
    .mclk(mclk),
    .reset(reset),
    .flush(mode_r == `ECPR_M_SPP),
    .pushValid(fifoPush),
    .pushData(fifoIn),
    .pushReady(fifoPushReady),
    .popValid(fifoValid),
    .popReady(fifoPop),
    .popData(fifoHead)
  );

  // Pins from the peripheral pass two flops before any use.
  always_ff @(posedge mclk)
  begin
    pinS1_r <= pinsIn;
    pinS_r <= pinS1_r;
    pdS1_r <= pdIn;
    pdS_r <= pdS1_r;
  end

  // Data latch clears at reset and takes host writes in every mode but 011.
  always_ff @(posedge mclk)
  begin
    if (reset)
      dataLatch_r <= `ECPR_BYTE_ZERO;
    else if (hostWr && hitData && (mode_r != `ECPR_M_ECP))
      dataLatch_r <= hostWdata;
  end

  // Only the low six control bits are stored; the top two stay zero.
  always_ff @(posedge mclk)
  begin
    if (reset)
      ctrl_r <= `ECPR_CTRL_RST;
    else if (hostWr && hitCtrl)
      ctrl_r <= hostWdata[`ECPR_C_DIR:`ECPR_C_STB];
  end

  // Extended control register: mode field and service bits.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mode_r <= `ECPR_M_SPP;
      errIe_r <= 1'b0;
      dmaEn_r <= 1'b0;
      svc_irq_flag_r <= 1'b0;
    end
    else if (hostWr && hitEcr)
    begin
      if (modeOk)
        mode_r <= newMode;
      errIe_r <= hostWdata[`ECPR_E_ERRIE];
      dmaEn_r <= hostWdata[`ECPR_E_DMAEN];
      svc_irq_flag_r <= hostWdata[`ECPR_E_SVC];
    end
  end

  // Handshake engine for forward sending and reverse capture.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      hs_r <= ST_IDLE;
      txByte_r <= `ECPR_BYTE_ZERO;
      txTag_r <= 1'b0;
    end
    else
    begin
      case (hs_r)
        ST_IDLE:
        begin
          // Load the head byte and strobe it out.
          if (autoFwd && fifoValid)
          begin
            txByte_r <= fifoHead[7:0];
            txTag_r <= fifoHead[8];
            hs_r <= ST_STROBE;
          end
          else if (autoRev)
            hs_r <= ST_RXACK;
        end
        ST_STROBE:
        begin
          // Busy rising means the peripheral took the byte.
          if (pinS_r.busy)
            hs_r <= ST_RELEASE;
        end
        ST_RELEASE:
        begin
          // Busy falling ends the transfer and pops the FIFO.
          if (!pinS_r.busy)
            hs_r <= ST_IDLE;
        end
        ST_RXACK:
        begin
          // Leaving reverse mode abandons the wait.
          if (!autoRev)
            hs_r <= ST_IDLE;
          else if (!pinS_r.ack)
            hs_r <= ST_RXDONE;
        end
        ST_RXDONE:
        begin
          // Wait for acknowledge to return high.
          if (pinS_r.ack)
            hs_r <= ST_IDLE;
        end
        default:
          hs_r <= ST_IDLE;
      endcase
    end
  end

  // Acknowledge edge raises a one-cycle interrupt request when enabled.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ackD_r <= 1'b1;
      irqOut <= 1'b0;
    end
    else
    begin
      ackD_r <= pinS_r.ack;
      irqOut <= ctrl_r[`ECPR_C_ACKIE] && pinS_r.ack && !ackD_r;
    end
  end

  // Control lines follow the control bits unless the engine owns them.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pinsOut.strobeN <= 1'b1;
      pinsOut.feedN <= 1'b1;
      pinsOut.init <= 1'b0;
      pinsOut.selInN <= 1'b1;
    end
    else
    begin
      pinsOut.init <= ctrl_r[`ECPR_C_INIT];
      pinsOut.selInN <= !ctrl_r[`ECPR_C_SELIN];
      if (autoFwd)
      begin
        pinsOut.strobeN <= (hs_r != ST_STROBE);
        pinsOut.feedN <= !((mode_r == `ECPR_M_ECP) && txTag_r);
      end
      else if (autoRev)
      begin
        pinsOut.strobeN <= !ctrl_r[`ECPR_C_STB];
        pinsOut.feedN <= (hs_r != ST_RXDONE);
      end
      else
      begin
        pinsOut.strobeN <= !ctrl_r[`ECPR_C_STB];
        pinsOut.feedN <= !ctrl_r[`ECPR_C_FEED];
      end
    end
  end

  // Data lines show the latch, the byte in flight or the test head.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pdOut <= `ECPR_BYTE_ZERO;
      pdOe <= 1'b1;
    end
    else
    begin
      pdOe <= !dirIn;
      if (autoFwd)
        pdOut <= txByte_r;
      else if (mode_r == `ECPR_M_TEST)
        pdOut <= fifoHead[7:0];
      else
        pdOut <= dataLatch_r;
    end
  end

  // Encodes the assigned interrupt line into three bits.
  function automatic logic [2:0] irqCode(input logic [3:0] n);
    case (n)
      4'hF: irqCode = 3'h6;
      4'hE: irqCode = 3'h5;
      4'hB: irqCode = 3'h4;
      4'hA: irqCode = 3'h3;
      4'h9: irqCode = 3'h2;
      4'h7: irqCode = 3'h1;
      4'h5: irqCode = 3'h7;
      default: irqCode = 3'h0;
    endcase
  endfunction

  // Read multiplexer, steered by offset and mode.
  always_comb
  begin
    rdMux = `ECPR_BYTE_ZERO;
    if (hitData && ((mode_r == `ECPR_M_SPP) || (mode_r == `ECPR_M_BIDIR)))
      rdMux = pdS_r;
    else if (hitStat)
      rdMux = {!pinS_r.busy, pinS_r.ack, pinS_r.paperErr, pinS_r.online,
        pinS_r.fault, `ECPR_LOW3};
    else if (hitCtrl)
      rdMux = {2'h0, ctrl_r};
    else if (hitFifo && (mode_r == `ECPR_M_CFG))
      rdMux = `ECPR_CFGA_VAL;
    else if (hitFifo && ((mode_r == `ECPR_M_TEST) || autoRev))
      rdMux = fifoValid ? fifoHead[7:0] : lastRd_r;
    else if (hitCfgb && (mode_r == `ECPR_M_CFG))
      rdMux = {1'b0, irqOut, irqCode(irqNumber),
        1'b0, dmaChannel};
    else if (hitEcr)
      rdMux = {mode_r, errIe_r, dmaEn_r, svc_irq_flag_r,
        !fifoPushReady, !fifoValid};
  end

  // Read data is registered on the read strobe and then held.
  always_ff @(posedge mclk)
  begin
    if (reset)
      hostRdata <= `ECPR_BYTE_ZERO;
    else if (hostRd)
      hostRdata <= rdMux;
  end

  // Remembers the last byte taken, for reads of an empty FIFO.
  always_ff @(posedge mclk)
  begin
    if (reset)
      lastRd_r <= `ECPR_BYTE_ZERO;
    else if (hostFifoRd && fifoValid)
      lastRd_r <= fifoHead[7:0];
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Checks that tie outputs to their causes.
  a_latch_reset: assert property ($past(reset) |-> dataLatch_r == 8'h00)
    else $error("Data latch not cleared by reset.");
  a_status_bits: assert property (hostRd && hitStat |=> hostRdata[2:0] == 3'h0
    && hostRdata[7] == !$past(pinS_r.busy)
    && hostRdata[3] == $past(pinS_r.fault))
    else $error("Status read gave wrong bits.");
  a_ctrl_top: assert property (hostRd && hitCtrl |=> hostRdata[7:6] == 2'h0)
    else $error("Control top bits not zero.");
  a_strobe_inv: assert property ((mode_r == `ECPR_M_SPP) && $stable(mode_r)
    |=> pinsOut.strobeN == !$past(ctrl_r[0]))
    else $error("Strobe not the inverse of its bit.");
  a_dir_forced: assert property ((mode_r == `ECPR_M_SPP) |=> pdOe)
    else $error("Data lines not driven in standard mode.");
  a_ack_irq: assert property (ctrl_r[4] && $rose(pinS_r.ack) |=> irqOut)
    else $error("Acknowledge edge gave no interrupt.");
  a_irq_cause: assert property (irqOut |-> $past(ctrl_r[4]))
    else $error("Interrupt without enable.");
  a_cfga_value: assert property (hostRd && hitFifo && (mode_r == `ECPR_M_CFG)
    |=> hostRdata == 8'h10)
    else $error("Configuration A value wrong.");
  a_cfgb_fields: assert property (hostRd && hitCfgb && (mode_r == `ECPR_M_CFG)
    |=> !hostRdata[7] && hostRdata[2] == 1'b0)
    else $error("Configuration B fields wrong.");
  a_empty_reread: assert property (hostFifoRd && !fifoValid
    |=> hostRdata == $past(lastRd_r) && $stable(lastRd_r))
    else $error("Empty FIFO read did not repeat.");
  a_full_drop: assert property (fifoPush && !fifoPushReady && !fifoPop
    |=> !fifoPushReady)
    else $error("Full FIFO flag dropped on discarded write.");

  c_test_read: cover property (hostFifoRd && fifoValid);
  c_fwd_send: cover property ((hs_r == ST_RELEASE) ##1 (hs_r == ST_IDLE));
  c_rev_capture: cover property (hs_r == ST_RXDONE);
endmodule // ecpr_regs
`default_nettype wire
